// ### scg_pkg.sv
// Constants, field layout and types of the sleep clock gating block.
// Assumes a 50 MHz APB clock and one shared asynchronous reset.
// Functional notes
// - Each gating bit enables one unit's clock
// - Access to gated-off unit raises bus fault
// - All gating bits reset to unclocked
// - Gating set follows run, sleep, deep-sleep state
// - Sleep sets apply only with auto gating
// - Bit 3 gates watchdog, resets zero
// - Bits 9:8 pick ADC rate, reset zero
// - Reserved bits read-only, read zero
package scg_pkg;

   // Clock rate of pclk
   localparam int CLK_HZ = 50_000_000;

   // Register byte addresses
   localparam logic [11:0] ADDR_SCG0 = 12'h110; // sleep_clock_gating_0
   localparam logic [11:0] ADDR_STAT = 12'h140; // Sticky event status, read-only
   localparam logic [11:0] ADDR_CLR  = 12'h144; // Status clear, write-only
   localparam logic [11:0] ADDR_IEN  = 12'h148; // Interrupt enable
   localparam logic [11:0] ADDR_EFF  = 12'h14C; // Effective gating and state

   // Field positions within sleep_clock_gating_0
   localparam int WDT_BIT  = 3;
   localparam int RATE_LSB = 8;
   localparam int RATE_MSB = 9;
   localparam int ADC_BIT  = 16;
   localparam int PWM_BIT  = 20;

   // Printed reset value and writable bits
   localparam logic [31:0] SCG0_RESET   = 32'h0000_0040;
   localparam logic [31:0] SCG0_RW_MASK = 32'h0011_0308;

   // Unit index order in the gate vectors
   localparam int N_UNITS = 3;
   localparam int U_WDT   = 0;
   localparam int U_PWM   = 1;
   localparam int U_ADC   = 2;
   localparam logic [2:0] UNITS_RESET = 3'h0;

   // ADC sample rate codes and rates
   localparam logic [1:0] RATE_125K = 2'h0;
   localparam logic [1:0] RATE_250K = 2'h1;
   localparam logic [1:0] RATE_500K = 2'h2;
   localparam int SPS_125K = 125_000;
   localparam int SPS_250K = 250_000;
   localparam int SPS_500K = 500_000;
   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] CYC_125K = CNT_W'(CLK_HZ / SPS_125K);
   localparam logic [CNT_W-1:0] CYC_250K = CNT_W'(CLK_HZ / SPS_250K);
   localparam logic [CNT_W-1:0] CYC_500K = CNT_W'(CLK_HZ / SPS_500K);

   // Status layout: faults per unit, then state entries
   localparam int STAT_W     = 5;
   localparam int ST_SLEEP   = 3;
   localparam int ST_DEEP    = 4;
   localparam logic [STAT_W-1:0] STAT_RESET = 5'h00;

   // Power mode input encoding
   localparam logic [1:0] PWR_RUN   = 2'h0;
   localparam logic [1:0] PWR_SLEEP = 2'h1;
   localparam logic [1:0] PWR_DEEP  = 2'h2;

   // Registered power state
   typedef enum logic [2:0]
   {
      SCG_RUN   = 3'b001,
      SCG_SLEEP = 3'b010,
      SCG_DEEP  = 3'b100
   } scg_pstate_t;

endpackage

// ### scg_rate_div.sv
// ADC sample pacing divider: one-cycle enable at the chosen rate.
// Assumes the rate code is stable or changes only between ticks.
`timescale 1ns/100ps
module scg_rate_div
   import scg_pkg::*;
(
   input  wire logic       clk,    // System clock
   input  wire logic       rst_n,  // Async reset, active low
   input  wire logic       run,    // ADC unit clocked
   input  wire logic [1:0] rate,   // Rate code
   output logic            tick    // Sample enable pulse
);

   logic [CNT_W-1:0] cnt_r;   // Down counter
   logic [CNT_W-1:0] period;  // Cycles per sample

   // Rate code to period; code 3 falls back to slowest
   always_comb
   begin
      unique case (rate)
         RATE_250K: period = CYC_250K;
         RATE_500K: period = CYC_500K;
         default:   period = CYC_125K;
      endcase
   end

   // Counter restarts whenever the ADC clock is gated off
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end
      else if (!run)
      begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end
      else if (cnt_r == '0)
      begin
         cnt_r <= period - CNT_W'(1);
         tick  <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r - CNT_W'(1);
         tick  <= 1'b0;
      end
   end

endmodule

// ### scg_ctrl.sv
// Sleep mode clock gating control with APB register access.
// Picks the unit clock enables from the power state and flags
// accesses to gated-off units. Run and deep-sleep gating sets and
// the auto gating bit come from neighbouring logic on pclk.
`timescale 1ns/100ps
module scg_ctrl
   import scg_pkg::*;
(
   input  wire logic         pclk,                    // APB clock, 50 MHz
   input  wire logic         presetn,                 // Async reset, active low
   input  wire logic         psel,                    // APB select
   input  wire logic         penable,                 // APB access phase
   input  wire logic         pwrite,                  // APB write
   input  wire logic [11:0]  paddr,                   // APB byte address
   input  wire logic [31:0]  pwdata,                  // APB write data
   output logic      [31:0]  prdata,                  // APB read data
   output logic              pready,                  // APB ready
   output logic              pslverr,                 // APB error
   input  wire logic [1:0]   power_mode,              // Core power state code
   input  wire logic [2:0]   run_clock_gating_0,      // Run gating per unit
   input  wire logic [2:0]   deep_sleep_clock_gating_0, // Deep gating per unit
   input  wire logic         auto_clock_gating_enable, // Auto gating bit
   input  wire logic [2:0]   periph_req,              // Unit access pulses
   output logic              watchdog_gate,           // Watchdog clock enable
   output logic              pwm_clk_en,              // PWM clock enable
   output logic              adc_clk_en,              // ADC clock enable
   output logic      [1:0]   adc_sample_rate_limit,   // ADC rate code
   output logic              adc_sample_tick,         // ADC sample enable
   output logic      [2:0]   periph_fault,            // Bus fault per unit
   output logic              irq                      // Level interrupt
);

   // Extract the unit gating bits of a gating register image
   function automatic logic [2:0] scg_units(input logic [31:0] r);
      scg_units = {r[ADC_BIT], r[PWM_BIT], r[WDT_BIT]};
   endfunction

   // Map the power mode code to a state
   function automatic scg_pstate_t scg_decode(input logic [1:0] m);
      unique case (m)
         PWR_SLEEP: scg_decode = SCG_SLEEP;
         PWR_DEEP:  scg_decode = SCG_DEEP;
         default:   scg_decode = SCG_RUN;   // Code 3 treated as run
      endcase
   endfunction

   logic [31:0]       scg0_r;       // sleep_clock_gating_0 storage
   logic [STAT_W-1:0] stat_r;       // Sticky event status
   logic [STAT_W-1:0] ien_r;        // Interrupt enable
   scg_pstate_t       pstate_r;     // Registered power state
   scg_pstate_t       pstate_nxt;   // Decoded power state
   logic [2:0]        gate_r;       // Effective unit enables
   logic [2:0]        gate_nxt;     // Enables for next cycle
   logic [2:0]        fault_r;      // Fault pulses
   logic [STAT_W-1:0] evt;          // Events this cycle
   logic [STAT_W-1:0] clr;          // Clear strobes this cycle
   logic [31:0]       rd_val;       // Read mux result
   logic              rd_hit;       // Address is readable
   logic              wr_hit;       // Address is writable
   logic              access;       // Access phase, not yet answered
   logic              done;         // Completing edge of a transfer
   logic              wr_done;      // Completing write
   logic              adc_tick;     // Divider pulse

   // One wait state: ready is raised one cycle into the access phase
   assign access  = psel & penable & ~pready;
   assign done    = psel & penable & pready;
   assign wr_done = done & pwrite & wr_hit & ~pslverr;

   // Address decode for reads and writes
   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      wr_hit = 1'b1;
      unique case (paddr)
         ADDR_SCG0:
         begin
            // Reserved bits read zero
            rd_val = scg0_r & SCG0_RW_MASK;
         end
         ADDR_STAT:
         begin
            rd_val = {{(32-STAT_W){1'b0}}, stat_r};
            wr_hit = 1'b0;                                 // Read-only
         end
         ADDR_CLR:
         begin
            rd_hit = 1'b0;                                 // Write-only
         end
         ADDR_IEN:
         begin
            rd_val = {{(32-STAT_W){1'b0}}, ien_r};
         end
         ADDR_EFF:
         begin
            rd_val = {24'h00_0000, 2'b00, pstate_r, gate_r};
            wr_hit = 1'b0;                                 // Read-only
         end
         default:
         begin
            rd_hit = 1'b0;                                 // Unmapped
            wr_hit = 1'b0;
         end
      endcase
   end

   // APB answer: ready, read data and error all registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (access)
      begin
         pready  <= 1'b1;
         pslverr <= pwrite ? ~wr_hit : ~rd_hit;
         prdata  <= (!pwrite && rd_hit) ? rd_val : 32'h0000_0000;
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

   // Sleep gating register: writes store only the defined fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Writable fields come up unclocked and slowest rate
         scg0_r <= SCG0_RESET;
      end
      else if (wr_done && paddr == ADDR_SCG0)
      begin
         // Reserved bits ignore writes
         scg0_r <= pwdata & SCG0_RW_MASK;
      end
   end

   // Interrupt enable register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ien_r <= STAT_RESET;
      end
      else if (wr_done && paddr == ADDR_IEN)
      begin
         ien_r <= pwdata[STAT_W-1:0];
      end
   end

   // Power state tracking; mode comes from pclk logic, no sync needed
   assign pstate_nxt = scg_decode(power_mode);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pstate_r <= SCG_RUN;
      end
      else
      begin
         pstate_r <= pstate_nxt;
      end
   end

   // Gating set selection by power state and auto gating
   always_comb
   begin
      gate_nxt = run_clock_gating_0;
      unique case (pstate_nxt)
         SCG_RUN:
         begin
            gate_nxt = run_clock_gating_0;
         end
         SCG_SLEEP:
         begin
            // Without auto gating sleep keeps the run set
            gate_nxt = auto_clock_gating_enable ?
                       scg_units(scg0_r) : run_clock_gating_0;
         end
         SCG_DEEP:
         begin
            gate_nxt = auto_clock_gating_enable ?
                       deep_sleep_clock_gating_0 : run_clock_gating_0;
         end
      endcase
   end

   // Effective enables registered so outputs are glitch free
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gate_r <= UNITS_RESET;
      end
      else
      begin
         gate_r <= gate_nxt;
      end
   end

   // Clock enable outputs, one per unit
   assign watchdog_gate = gate_r[U_WDT];
   assign pwm_clk_en    = gate_r[U_PWM];
   assign adc_clk_en    = gate_r[U_ADC];

   // ADC rate code straight from the stored field
   assign adc_sample_rate_limit = scg0_r[RATE_MSB:RATE_LSB];

   // Access to a unit whose clock is off answers with a bus fault
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fault_r <= 3'h0;
      end
      else
      begin
         fault_r <= periph_req & ~gate_r;
      end
   end

   assign periph_fault = fault_r;

   // Events: faults per unit and entry into sleep states
   always_comb
   begin
      evt = STAT_RESET;
      evt[N_UNITS-1:0] = periph_req & ~gate_r;
      evt[ST_SLEEP] = (pstate_nxt == SCG_SLEEP) && (pstate_r != SCG_SLEEP);
      evt[ST_DEEP]  = (pstate_nxt == SCG_DEEP) && (pstate_r != SCG_DEEP);
   end

   // Write-one-to-clear strobes
   assign clr = (wr_done && paddr == ADDR_CLR) ? pwdata[STAT_W-1:0] : STAT_RESET;

   // Sticky status bits; a new event beats a clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < STAT_W; gi++)
      begin : g_stat
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               stat_r[gi] <= 1'b0;
            end
            else if (evt[gi])
            begin
               stat_r[gi] <= 1'b1;
            end
            else if (clr[gi])
            begin
               stat_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Interrupt level from enabled status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |((stat_r | evt) & ien_r & ~(clr & ~evt));
      end
   end

   // Sample pacing runs only while the ADC is clocked
   scg_rate_div u_div
   (
      .clk   (pclk),
      .rst_n (presetn),
      .run   (gate_r[U_ADC]),
      .rate  (scg0_r[RATE_MSB:RATE_LSB]),
      .tick  (adc_tick)
   );

   assign adc_sample_tick = adc_tick;

endmodule

// ### scg_ctrl_asserts.sv
// Port checker for the sleep clock gating control block.
// Assumes it is bound to scg_ctrl and sees only its ports.
`timescale 1ns/100ps
module scg_ctrl_asserts
   import scg_pkg::*;
(
   input wire logic        pclk,                      // Clock
   input wire logic        presetn,                   // Reset, low
   input wire logic        psel,                      // Select
   input wire logic        penable,                   // Access
   input wire logic        pwrite,                    // Write
   input wire logic [11:0] paddr,                     // Address
   input wire logic [31:0] prdata,                    // Read data
   input wire logic        pready,                    // Ready
   input wire logic [1:0]  power_mode,                // Power state
   input wire logic [2:0]  run_clock_gating_0,        // Run set
   input wire logic [2:0]  deep_sleep_clock_gating_0, // Deep set
   input wire logic        auto_clock_gating_enable,  // Auto bit
   input wire logic [2:0]  periph_req,                // Unit access
   input wire logic        watchdog_gate,             // Wdt enable
   input wire logic        pwm_clk_en,                // Pwm enable
   input wire logic        adc_clk_en,                // Adc enable
   input wire logic [1:0]  adc_sample_rate_limit,     // Rate code
   input wire logic        adc_sample_tick,           // Sample pulse
   input wire logic [2:0]  periph_fault               // Fault pulses
);
   logic [2:0] gates;  // Enables {adc,pwm,wdt}
   logic [8:0] gap_r;  // Cycles since last tick
   logic       had_r;  // Earlier tick in this on-spell
   logic [8:0] per;    // Expected tick period
   assign gates = {adc_clk_en, pwm_clk_en, watchdog_gate};
   // Code 3 is forbidden to software but paces like code 0
   assign per = (adc_sample_rate_limit == RATE_500K) ? 9'h064 :
                (adc_sample_rate_limit == RATE_250K) ? 9'h0C8 : 9'h190;
   // Tick gap counter; first tick after enabling is not a period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_r <= 9'h000;
         had_r <= 1'b0;
      end
      else
      begin
         gap_r <= adc_sample_tick ? 9'h001 : gap_r + 9'h001;
         had_r <= adc_clk_en & (had_r | adc_sample_tick);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_scg_read;
      pready && !pwrite && paddr == ADDR_SCG0;
   endsequence
   sequence s_adc_on;
      $rose(adc_clk_en);
   endsequence
   property p_pready_wait;
      s_access |=> pready;
   endproperty
   a_pready_wait: assert property (p_pready_wait) else $error("pready late");
   property p_run_gate;
      power_mode == PWR_RUN |=> gates == $past(run_clock_gating_0);
   endproperty
   a_run_gate: assert property (p_run_gate) else $error("run set not used");
   property p_deep_gate;
      power_mode == PWR_DEEP && auto_clock_gating_enable |=> gates == $past(deep_sleep_clock_gating_0);
   endproperty
   a_deep_gate: assert property (p_deep_gate) else $error("deep set not used");
   property p_noauto_gate;
      power_mode != PWR_RUN && !auto_clock_gating_enable |=> gates == $past(run_clock_gating_0);
   endproperty
   a_noauto_gate: assert property (p_noauto_gate) else $error("auto off ignored");
   property p_fault;
      1'b1 |=> periph_fault == ($past(periph_req) & ~$past(gates));
   endproperty
   a_fault: assert property (p_fault) else $error("fault mismatch");
   property p_reserved_rd;
      s_scg_read |-> (prdata & ~SCG0_RW_MASK) == 32'h0000_0000;
   endproperty
   a_reserved_rd: assert property (p_reserved_rd) else $error("reserved bit set");
   property p_rate_rd;
      s_scg_read |-> prdata[RATE_MSB:RATE_LSB] == adc_sample_rate_limit;
   endproperty
   a_rate_rd: assert property (p_rate_rd) else $error("rate field mismatch");
   property p_tick_first;
      s_adc_on |=> adc_sample_tick;
   endproperty
   a_tick_first: assert property (p_tick_first) else $error("no first tick");
   property p_tick_period;
      adc_sample_tick && had_r |-> gap_r == per;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
endmodule

// ### sleep_mode_clock_gating_bench.sv
// Self-checking bench for the sleep clock gating control block.
// Assumes scg_pkg and scg_ctrl are compiled first.
`timescale 1ns/100ps
module sleep_mode_clock_gating_bench
   import scg_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        auto_clock_gating_enable, irq, adc_sample_tick;
   logic        watchdog_gate, pwm_clk_en, adc_clk_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [1:0]  power_mode, adc_sample_rate_limit;
   logic [2:0]  run_clock_gating_0, deep_sleep_clock_gating_0, periph_req, periph_fault;
   int          failures, n_checks, cyc;
   scg_ctrl u_scg_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .power_mode(power_mode), .run_clock_gating_0(run_clock_gating_0),
      .deep_sleep_clock_gating_0(deep_sleep_clock_gating_0),
      .auto_clock_gating_enable(auto_clock_gating_enable), .periph_req(periph_req),
      .watchdog_gate(watchdog_gate), .pwm_clk_en(pwm_clk_en), .adc_clk_en(adc_clk_en),
      .adc_sample_rate_limit(adc_sample_rate_limit), .adc_sample_tick(adc_sample_tick),
      .periph_fault(periph_fault), .irq(irq));
   // 50 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // Hang guard, far above the few thousand cycles needed
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic eerr);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the hang guard ends a stuck wait
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      chk("pready", 32'h1, {31'h0, pready});
      chk("pslverr", {31'h0, eerr}, {31'h0, pslverr});
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
      apb(1'b0, a, 32'h0, eerr);
      chk("prdata", exp, q);
   endtask
   // Enables settle one edge after the inputs
   task automatic gates_are(input logic [2:0] exp);
      repeat (3) @(posedge pclk);
      chk("gates", {29'h0, exp}, {29'h0, adc_clk_en, pwm_clk_en, watchdog_gate});
   endtask
   task automatic mode(input logic [1:0] pm, input logic au, input logic [2:0] exp);
      power_mode <= pm;
      auto_clock_gating_enable <= au;
      gates_are(exp);
   endtask
   task automatic t_reset();
      gates_are(3'h0);
      rd(ADDR_SCG0, SCG0_RESET & SCG0_RW_MASK, 1'b0);
      chk("rate", {30'h0, RATE_125K}, {30'h0, adc_sample_rate_limit});
   endtask
   task automatic t_regs();
      apb(1'b1, ADDR_SCG0, 32'hFFFF_FEFF, 1'b0);
      rd(ADDR_SCG0, 32'h0011_0208, 1'b0);
      chk("rate", {30'h0, RATE_500K}, {30'h0, adc_sample_rate_limit});
      rd(12'h200, 32'h0, 1'b1);
      apb(1'b1, ADDR_STAT, 32'hFFFF_FFFF, 1'b1);
      rd(ADDR_CLR, 32'h0, 1'b1);
   endtask
   // Sleep register holds all three units enabled here
   task automatic t_select();
      deep_sleep_clock_gating_0 <= 3'h2;
      mode(PWR_RUN, 1'b1, 3'h0);
      mode(PWR_SLEEP, 1'b1, 3'h7);
      mode(PWR_DEEP, 1'b1, 3'h2);
      rd(ADDR_EFF, 32'h0000_0022, 1'b0);
      mode(PWR_SLEEP, 1'b0, 3'h0);
      mode(PWR_DEEP, 1'b0, 3'h0);
      mode(PWR_SLEEP, 1'b1, 3'h7);
      apb(1'b1, ADDR_SCG0, 32'h0000_0008, 1'b0);
      gates_are(3'h1);
      apb(1'b1, ADDR_SCG0, 32'h0010_0000, 1'b0);
      gates_are(3'h2);
      apb(1'b1, ADDR_SCG0, 32'h0001_0000, 1'b0);
      gates_are(3'h4);
      // Read-modify-write keeps the other fields as read
      rd(ADDR_SCG0, 32'h0001_0000, 1'b0);
      apb(1'b1, ADDR_SCG0, q | 32'h0000_0008, 1'b0);
      gates_are(3'h5);
   endtask
   // Watchdog gated off, pwm on: only the watchdog access faults
   task automatic t_fault();
      run_clock_gating_0 <= 3'h6;
      // Sleep and deep entries from the selection scenario
      rd(ADDR_STAT, 32'h0000_0018, 1'b0);
      mode(2'h3, 1'b1, 3'h6);
      mode(PWR_RUN, 1'b0, 3'h6);
      apb(1'b1, ADDR_CLR, 32'h0000_001F, 1'b0);
      apb(1'b1, ADDR_IEN, 32'h0000_0001, 1'b0);
      @(posedge pclk);
      periph_req <= 3'h3;
      @(posedge pclk);
      periph_req <= 3'h0;
      @(posedge pclk);
      chk("fault", 32'h1, {29'h0, periph_fault});
      rd(ADDR_STAT, 32'h1, 1'b0);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, ADDR_IEN, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, ADDR_IEN, 32'h1, 1'b0);
      apb(1'b1, ADDR_CLR, 32'h1, 1'b0);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      rd(ADDR_STAT, 32'h0, 1'b0);
   endtask
   // Rate changed only while the converter is gated
   task automatic t_tick();
      int sps[3];
      int k;
      sps = '{SPS_125K, SPS_250K, SPS_500K};
      for (int c = 0; c < 3; c++)
      begin
         run_clock_gating_0 <= 3'h0;
         apb(1'b1, ADDR_SCG0, 32'(c) << RATE_LSB, 1'b0);
         run_clock_gating_0 <= 3'h4;
         repeat (5) @(posedge pclk);
         k = 0;
         repeat (800)
         begin
            @(posedge pclk);
            if (adc_sample_tick === 1'b1)
               k++;
         end
         chk("ticks", 32'(800 / (CLK_HZ / sps[c])), 32'(k));
      end
   endtask
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, auto_clock_gating_enable} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      power_mode = PWR_RUN;
      {run_clock_gating_0, deep_sleep_clock_gating_0, periph_req} = 9'h000;
      {failures, n_checks, cyc} = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_regs();
      t_select();
      t_fault();
      t_tick();
      give_verdict();
   end
endmodule
bind scg_ctrl scg_ctrl_asserts u_scg_ctrl_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .power_mode(power_mode), .run_clock_gating_0(run_clock_gating_0),
   .deep_sleep_clock_gating_0(deep_sleep_clock_gating_0),
   .auto_clock_gating_enable(auto_clock_gating_enable), .periph_req(periph_req),
   .watchdog_gate(watchdog_gate), .pwm_clk_en(pwm_clk_en), .adc_clk_en(adc_clk_en),
   .adc_sample_rate_limit(adc_sample_rate_limit), .adc_sample_tick(adc_sample_tick),
   .periph_fault(periph_fault));
